/* src/copro_pkg.sv */
// shared constants for the coprocessor bus interface
package copro_pkg;
  localparam int         DATA_W       = 32;
  localparam int         SEL_W        = 3;
  localparam int         CODE_W       = 4;
  localparam int         NUM_PREG     = 8;
  localparam logic [3:0] CODE_DWRITE  = 4'h1;
  localparam logic [3:0] CODE_AUTOVEC = 4'h2;
  localparam logic [3:0] CODE_DFETCH  = 4'h3;
  localparam logic [3:0] CODE_BCAST   = 4'h5;
  localparam logic [3:0] CODE_SFETCH  = 4'h6;
  localparam logic [3:0] CODE_INTACK  = 4'hB;
  localparam int         EXEC_CYCLES  = 4;
  localparam logic [7:0] EXEC_LAST    = 8'(EXEC_CYCLES - 1);
  localparam logic [7:0] CNT_ZERO     = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [2:0] RESET_CYCLES = 3'h7;
  localparam logic [2:0] RST_ZERO     = 3'h0;
  localparam logic [2:0] RST_ONE      = 3'h1;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
  localparam int         FAULT_BIT    = 31;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_PACK  = 3'b010,
    ST_CACC  = 3'b011,
    ST_EXEC  = 3'b100
  } bus_state_e;
endpackage : copro_pkg

/* src/cycle_decode.sv */
// access-code decoder for coprocessor bus cycles
module cycle_decode
  import copro_pkg::*;
(
  // cycle description
  input  wire logic [CODE_W-1:0] access_code,
  // decoded kinds
  output logic                   is_bcast,
  output logic                   is_sfetch,
  output logic                   is_dwrite,
  output logic                   is_dfetch,
  output logic                   is_copro
);
  always_comb
  begin
    is_bcast  = (access_code == CODE_BCAST);
    is_sfetch = (access_code == CODE_SFETCH);
    is_dwrite = (access_code == CODE_DWRITE);
    is_dfetch = (access_code == CODE_DFETCH);
    // interrupt acknowledges and other codes fall through as non-coprocessor
    is_copro  = is_bcast | is_sfetch | is_dwrite | is_dfetch;
  end
endmodule : cycle_decode

/* src/out_float.sv */
// output gating for bus shadow and test float
module out_float
  import copro_pkg::*;
(
  // controls
  input  wire logic              test_float_all,
  input  wire logic              bus_shadow_in,
  // raw enables
  input  wire logic              data_drive,
  input  wire logic              ctl_drive,
  // gated enables
  output logic                   data_oe,
  output logic                   ctl_oe
);
  always_comb
  begin
    data_oe = data_drive & ~bus_shadow_in & ~test_float_all;
    ctl_oe  = ctl_drive & ~test_float_all;
  end
endmodule : out_float

/* src/float_coprocessor_bus_interface.sv */
// bus interface of the floating-point coprocessor
module float_coprocessor_bus_interface
  import copro_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // phase clocks sampled as ordinary inputs
  input  wire logic              phase_clk_a,
  input  wire logic              phase_clk_b,
  // bus control from host
  input  wire logic              chip_select_n,
  input  wire logic              cycle_begin,
  input  wire logic              bus_ok_in,
  input  wire logic              xfer_strobe_n,
  input  wire logic              read_not_write,
  input  wire logic [CODE_W-1:0] access_code,
  input  wire logic [SEL_W-1:0]  reg_select_addr,
  input  wire logic              bus_shadow_in,
  input  wire logic              test_float_all,
  // data bus
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  // handshake outputs, all sharing the one enable ctl_oe
  output logic                   xfer_ack_n,
  output logic                   sync_ready_n,
  output logic                   done_n,
  output logic                   fault_n,
  output logic                   ctl_oe,
  // execution side
  input  wire logic              exec_exception,
  output logic                   in_reset
);
  bus_state_e              state;
  bus_state_e              next_state;
  logic [DATA_W-1:0]       preg [NUM_PREG];
  logic [DATA_W-1:0]       operand;
  logic [DATA_W-1:0]       next_operand;
  logic [DATA_W-1:0]       rd_data;
  logic [DATA_W-1:0]       next_rd_data;
  logic [7:0]              exec_cnt;
  logic [7:0]              next_exec_cnt;
  logic [2:0]              rst_cnt;
  logic [2:0]              next_rst_cnt;
  logic                    phase_b_q;
  logic                    cycle_start;
  logic                    busy;
  logic                    next_busy;
  logic                    done_flag;
  logic                    next_done_flag;
  logic                    fault_flag;
  logic                    next_fault_flag;
  logic                    ack;
  logic                    sync_rdy;
  logic                    data_drive;
  logic                    preg_wr;
  logic                    cur_bcast;
  logic                    next_cur_bcast;
  logic                    cur_sfetch;
  logic                    next_cur_sfetch;
  logic                    cur_dwrite;
  logic                    next_cur_dwrite;
  logic                    cur_dfetch;
  logic                    next_cur_dfetch;
  logic                    is_bcast;
  logic                    is_sfetch;
  logic                    is_dwrite;
  logic                    is_dfetch;
  logic                    is_copro;
  logic                    periph_mode;
  logic                    strobe;

  cycle_decode u_decode (
    .access_code (access_code),
    .is_bcast    (is_bcast),
    .is_sfetch   (is_sfetch),
    .is_dwrite   (is_dwrite),
    .is_dfetch   (is_dfetch),
    .is_copro    (is_copro)
  );

  out_float u_float (
    .test_float_all (test_float_all),
    .bus_shadow_in  (bus_shadow_in),
    .data_drive     (data_drive),
    .ctl_drive      (state != ST_RESET),
    .data_oe        (data_oe),
    .ctl_oe         (ctl_oe)
  );

  assign periph_mode = ~chip_select_n;
  assign strobe      = ~xfer_strobe_n;
  // falling edge of the lagging phase clock opens a machine cycle; the
  // leading clock is low there, which rejects a glitch on the lagging one
  assign cycle_start = phase_b_q & ~phase_clk_b & ~phase_clk_a;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_b_q <= 1'b0;
    else
      phase_b_q <= phase_clk_b;
  end

  always_comb
  begin
    next_state      = state;
    next_operand    = operand;
    next_rd_data    = rd_data;
    next_exec_cnt   = exec_cnt;
    next_rst_cnt    = rst_cnt;
    next_busy       = busy;
    next_done_flag  = done_flag;
    next_fault_flag = fault_flag;
    next_cur_bcast  = cur_bcast;
    next_cur_sfetch = cur_sfetch;
    next_cur_dwrite = cur_dwrite;
    next_cur_dfetch = cur_dfetch;
    ack             = 1'b0;
    sync_rdy        = 1'b0;
    data_drive      = 1'b0;
    preg_wr         = 1'b0;
    unique case (state)
      ST_RESET:
      begin
        // reset routine: clear status and count out a short settle
        next_busy       = 1'b0;
        next_done_flag  = 1'b0;
        next_fault_flag = 1'b0;
        next_rst_cnt    = rst_cnt + RST_ONE;
        if (rst_cnt == RESET_CYCLES)
          next_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (periph_mode && strobe)
        begin
          // register select and direction sampled with the strobe
          if (read_not_write)
            next_rd_data = preg[reg_select_addr];
          else
            preg_wr = 1'b1;
          next_state = ST_PACK;
        end
        else if (!periph_mode && cycle_begin && is_copro)
        begin
          // while busy only broadcasts are honoured
          if (!busy || is_bcast)
          begin
            if (is_sfetch)
              next_rd_data = {fault_flag, {(DATA_W-2){1'b0}}, done_flag};
            else if (is_dfetch)
              next_rd_data = operand;
            // the code is only held around the cycle start, so its kind is kept
            next_cur_bcast  = is_bcast;
            next_cur_sfetch = is_sfetch;
            next_cur_dwrite = is_dwrite;
            next_cur_dfetch = is_dfetch;
            next_state = ST_CACC;
          end
        end
      end
      ST_PACK:
      begin
        ack        = 1'b1;
        // rd_data was loaded at take, so the bus holds still all strobe long
        data_drive = read_not_write & strobe;
        if (!strobe)
          next_state = ST_IDLE;
      end
      ST_CACC:
      begin
        data_drive = read_not_write & strobe & (cur_sfetch | cur_dfetch);
        if (cur_bcast || cur_sfetch)
          sync_rdy = 1'b1;
        // only a cycle free of bus exceptions takes effect
        if (bus_ok_in && cycle_start)
        begin
          if (cur_dwrite && strobe)
            next_operand = data_in;
          if (cur_bcast)
          begin
            next_busy       = 1'b1;
            next_done_flag  = 1'b0;
            next_fault_flag = 1'b0;
            next_exec_cnt   = CNT_ZERO;
            next_state      = ST_EXEC;
          end
          else
            next_state = ST_IDLE;
        end
        // host abandoned the cycle after a bus exception
        else if (!cycle_begin && !strobe && !bus_ok_in)
          next_state = ST_IDLE;
      end
      ST_EXEC:
      begin
        // stand-in execution: fixed length, exception latches sticky
        next_exec_cnt = exec_cnt + CNT_ONE;
        if (exec_exception)
          next_fault_flag = 1'b1;
        if (exec_cnt == EXEC_LAST)
        begin
          next_busy      = 1'b0;
          next_done_flag = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      default:
        next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= ST_RESET;
      operand    <= DATA_ZERO;
      rd_data    <= DATA_ZERO;
      exec_cnt   <= CNT_ZERO;
      rst_cnt    <= RST_ZERO;
      busy       <= 1'b0;
      done_flag  <= 1'b0;
      fault_flag <= 1'b0;
      cur_bcast  <= 1'b0;
      cur_sfetch <= 1'b0;
      cur_dwrite <= 1'b0;
      cur_dfetch <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      operand    <= next_operand;
      rd_data    <= next_rd_data;
      exec_cnt   <= next_exec_cnt;
      rst_cnt    <= next_rst_cnt;
      busy       <= next_busy;
      done_flag  <= next_done_flag;
      fault_flag <= next_fault_flag;
      cur_bcast  <= next_cur_bcast;
      cur_sfetch <= next_cur_sfetch;
      cur_dwrite <= next_cur_dwrite;
      cur_dfetch <= next_cur_dfetch;
    end
  end

  // peripheral registers, written only from a selected write strobe
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PREG; gi++)
    begin : g_preg
      logic [DATA_W-1:0] next_val;
      always_comb
      begin
        next_val = preg[gi];
        if (preg_wr && (reg_select_addr == SEL_W'(gi)))
          next_val = data_in;
      end
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          preg[gi] <= DATA_ZERO;
        else
          preg[gi] <= next_val;
      end
    end
  endgenerate

  // status pins come straight from flags; their enable comes from out_float
  always_comb
  begin
    data_out     = rd_data;
    xfer_ack_n   = ~ack;
    sync_ready_n = ~sync_rdy;
    done_n       = ~done_flag;
    fault_n      = ~fault_flag;
    in_reset     = (state == ST_RESET);
  end
endmodule : float_coprocessor_bus_interface

/* bench/host_model.sv */
// host model: free-running phase clocks and host data drive
module host_model
  import copro_pkg::*;
(
  // clock
  input  wire logic              clk,
  // host data
  input  wire logic              drv,
  input  wire logic [DATA_W-1:0] val,
  output logic      [DATA_W-1:0] data_in,
  // phase clocks
  output logic                   phase_clk_a,
  output logic                   phase_clk_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]        ph = 2'h0;
  logic [DATA_W-1:0] last = DATA_ZERO;
  always_ff @(posedge clk)
  begin
    ph <= ph + 2'h1;
    if (drv)
      last <= val;
  end
  // four clk per phase period, b a quarter behind a
  assign phase_clk_a = ph[1];
  assign phase_clk_b = ~(ph[1] ^ ph[0]);
  // released bus shows the inverse, never a stale match
  assign data_in = drv ? val : ~last;
endmodule : host_model

/* bench/bus_if_chk.sv */
// checker for the coprocessor bus interface ports
module bus_if_chk
  import copro_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // host side
  input wire logic              chip_select_n,
  input wire logic              cycle_begin,
  input wire logic              xfer_strobe_n,
  input wire logic [CODE_W-1:0] access_code,
  input wire logic              bus_shadow_in,
  input wire logic              test_float_all,
  // device side
  input wire logic              data_oe,
  input wire logic              xfer_ack_n,
  input wire logic              sync_ready_n,
  input wire logic              ctl_oe,
  input wire logic              in_reset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_float_all: assert property (test_float_all |-> !data_oe && !ctl_oe)
    else $error("outputs driven in float test");
  a_shadow_data: assert property (bus_shadow_in |-> !data_oe)
    else $error("data driven under shadow");
  a_read_window: assert property (data_oe |-> !xfer_strobe_n || !$past(xfer_strobe_n))
    else $error("data driven without strobe");
  a_ack_release: assert property (xfer_strobe_n |=> xfer_ack_n)
    else $error("ack held after strobe high");
  a_ack_answer: assert property (!chip_select_n && !xfer_strobe_n && xfer_ack_n && !in_reset
    |=> !xfer_ack_n)
    else $error("no ack for peripheral access");
  a_ready_mode: assert property (!sync_ready_n |-> chip_select_n)
    else $error("sync ready in peripheral mode");
  a_ready_ignore: assert property (cycle_begin && chip_select_n && sync_ready_n
    && (access_code == CODE_INTACK || access_code == CODE_AUTOVEC) |=> sync_ready_n)
    else $error("sync ready for foreign cycle");
  a_ready_answer: assert property ($rose(cycle_begin) && chip_select_n && !in_reset
    && (access_code == CODE_BCAST || access_code == CODE_SFETCH) |=> !sync_ready_n)
    else $error("no sync ready for broadcast or status");
  a_reset_quiet: assert property (in_reset |-> !ctl_oe)
    else $error("control driven in reset routine");
endmodule : bus_if_chk

/* bench/testbench.sv */
// self-checking bench for the coprocessor bus interface
module testbench
  import copro_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int D = 10;
  logic clk, rstn, pa, pb, cs_n, cyc, ok, stb_n, rnw, shd, flt, exc, drv;
  logic [3:0] code;
  logic [2:0] sel;
  logic [31:0] din, dout, val, got, q, seed;
  logic [31:0] w [NUM_PREG];
  logic oe, ack_n, rdy_n, done_n, fault_n, coe, inr, pbq, last;
  int failures, compares, i, k;
  host_model u_host (.clk(clk), .drv(drv), .val(val), .data_in(din), .phase_clk_a(pa),
    .phase_clk_b(pb));
  float_coprocessor_bus_interface u_dut (.clk(clk), .rstn(rstn), .phase_clk_a(pa),
    .phase_clk_b(pb), .chip_select_n(cs_n), .cycle_begin(cyc), .bus_ok_in(ok),
    .xfer_strobe_n(stb_n), .read_not_write(rnw), .access_code(code), .reg_select_addr(sel),
    .bus_shadow_in(shd), .test_float_all(flt), .data_in(din), .data_out(dout),
    .data_oe(oe), .xfer_ack_n(ack_n), .sync_ready_n(rdy_n), .done_n(done_n),
    .fault_n(fault_n), .ctl_oe(coe), .exec_exception(exc), .in_reset(inr));
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("Error %0t mismatch seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  function automatic logic rdy_exp(input logic [3:0] c);
    return !(c == CODE_BCAST || c == CODE_SFETCH);
  endfunction : rdy_exp
  task tick;
    @(posedge clk);
    #D;
  endtask : tick
  // peripheral access; f also pulses shadow and float mid-read
  task per(input logic [2:0] s, input logic r, input logic [31:0] wd, input logic f);
    tick();
    cs_n = 0;
    sel = s;
    rnw = r;
    stb_n = 0;
    drv = !r;
    val = wd;
    for (k = 0; k < 8 && ack_n !== 0; k++)
      tick();
    chk(32'(ack_n), 0);
    chk(32'(oe), 32'(r));
    q = dout;
    if (f)
    begin
      shd = 1;
      #1 chk(32'(oe), 0);
      flt = 1;
      #1 chk(32'({oe, coe}), 0);
      // hold both across an edge so the checker sees them
      tick();
      chk(32'({oe, coe}), 0);
      shd = 0;
      flt = 0;
    end
    stb_n = 1;
    drv = 0;
    tick();
    chk(32'(ack_n), 1);
    cs_n = 1;
  endtask : per
  // coprocessor cycle, read data kept in got; o low models a bus exception
  task cop(input logic [3:0] c, input logic r, input logic [31:0] wd, input logic o);
    tick();
    cyc = 1;
    code = c;
    rnw = r;
    stb_n = 0;
    drv = !r;
    val = wd;
    tick();
    chk(32'(rdy_n), 32'(rdy_exp(c)));
    ok = o;
    last = 0;
    // hold the cycle up to the edge that opens the next machine cycle
    for (k = 0; k < 6 && !last; k++)
    begin
      last = pbq & ~pb;
      if (oe === 1)
        got = dout;
      tick();
    end
    chk(32'(rdy_n), 32'(o | rdy_exp(c)));
    cyc = 0;
    ok = 0;
    stb_n = 1;
    drv = 0;
    code = 4'h0;
  endtask : cop
  task wait_exec;
    for (k = 0; k < 16 && done_n !== 0; k++)
      tick();
  endtask : wait_exec
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    pbq <= pb;
  initial
  begin
    #100000;
    failures++;
    summarize();
  end
  initial
  begin
    seed = 32'h76E7FD87;
    {rstn, cyc, ok, rnw, shd, flt, exc, drv, code, sel, val, got} = '0;
    {cs_n, stb_n} = 2'h3;
    #D chk(32'({inr, coe, ack_n, rdy_n}), 32'hB);
    repeat (10) @(posedge clk);
    #D rstn = 1;
    for (i = 0; i < 12 && inr !== 0; i++)
      tick();
    chk(32'(inr), 0);
    for (i = 0; i < NUM_PREG; i++)
    begin
      w[i] = $random(seed);
      per(3'(i), 0, w[i], 0);
    end
    for (i = NUM_PREG - 1; i >= 0; i--)
    begin
      per(3'(i), 1, 32'h0, i == 2);
      chk(q, w[i]);
    end
    cop(CODE_INTACK, 1, 32'h0, 1);
    cop(CODE_AUTOVEC, 1, 32'h0, 1);
    cop(CODE_BCAST, 0, 32'h0, 1);
    wait_exec();
    chk(32'({done_n, fault_n}), 32'h1);
    cop(CODE_BCAST, 0, 32'h0, 0);
    chk(32'(done_n), 0);
    cop(CODE_SFETCH, 1, 32'h0, 1);
    chk(32'({got[31], got[0]}), 32'h1);
    val = $random(seed);
    cop(CODE_DWRITE, 0, val, 1);
    q = val;
    cop(CODE_DFETCH, 1, 32'h0, 1);
    chk(got, q);
    exc = 1;
    cop(CODE_BCAST, 0, 32'h0, 1);
    wait_exec();
    exc = 0;
    chk(32'(fault_n), 0);
    cop(CODE_SFETCH, 1, 32'h0, 1);
    chk(32'(got[31]), 1);
    summarize();
  end
endmodule : testbench
bind float_coprocessor_bus_interface bus_if_chk u_chk (.clk(clk), .rstn(rstn),
  .chip_select_n(chip_select_n), .cycle_begin(cycle_begin), .xfer_strobe_n(xfer_strobe_n),
  .access_code(access_code), .bus_shadow_in(bus_shadow_in), .test_float_all(test_float_all),
  .data_oe(data_oe), .xfer_ack_n(xfer_ack_n), .sync_ready_n(sync_ready_n), .ctl_oe(ctl_oe),
  .in_reset(in_reset));
